// *** logic/bgp_gpio_port.sv ***
// Eight-pin general-purpose port with its direction and level registers
// on the bridge configuration access path.
// Assumes configuration requests arrive synchronous to MCLK, one per
// cycle, with a byte address naming the low byte of a 16-bit register.
`timescale 1ns/1ps
`default_nettype none

module bgp_gpio_port #(
  parameter int unsigned PINS = bgp_pkg::PIN_COUNT
) (
  // Clock and resets, all synchronous and active high.
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire logic             PCIE_RST,
  input  wire logic             GLOBAL_RESET_INPUT,
  // Configuration access path.
  input  wire logic [7:0]       CFG_ADDR,
  input  wire logic             CFG_WR,
  input  wire logic             CFG_RD,
  input  wire logic [1:0]       CFG_BE,
  input  wire logic [15:0]      CFG_WDATA,
  output logic      [15:0]      CFG_RDATA,
  output logic                  CFG_RVALID,
  // Secondary function enables.
  input  wire logic             CLOCK_RUN_ENABLE,
  input  wire logic             POWER_OVERRIDE_ENABLE,
  input  wire logic             SERIAL_EEPROM_PRESENT_ENABLE,
  // Secondary function drives towards the pins.
  input  wire logic             CLOCK_RUN_OUT,
  input  wire logic             CLOCK_RUN_OE_N,
  input  wire logic             SCL_OUT,
  input  wire logic             SCL_OE_N,
  input  wire logic             SDA_OUT,
  input  wire logic             SDA_OE_N,
  // Secondary function levels taken from the pins.
  output logic                  CLOCK_RUN_FUNCTION,
  output logic                  POWER_OVERRIDE_INPUT,
  output logic                  SCL_IN,
  output logic                  SDA_IN,
  // Pins: input, output and output enable (low while driving).
  input  wire logic [PINS-1:0]  GP_IN,
  output logic      [PINS-1:0]  GP_OUT,
  output logic      [PINS-1:0]  GP_OE_N
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic            any_rst;        // Any of the three resets.
  logic [PINS-1:0] direction;      // One bit per pin, 1 = output.
  logic [PINS-1:0] next_direction; // Direction for the next cycle.
  logic [PINS-1:0] level;          // Output level latch.
  logic [PINS-1:0] next_level;     // Level latch for the next cycle.
  logic [PINS-1:0] sec_enable;     // Pins given to a secondary function.
  logic [PINS-1:0] sec_out;        // Secondary drive values.
  logic [PINS-1:0] sec_oe_n;       // Secondary drive enables.
  logic [PINS-1:0] write_ok;       // Pins that accept a data write.
  logic [PINS-1:0] read_level;     // Value the data register shows.
  logic            hit_dir;        // Request names the direction register.
  logic            hit_data;       // Request names the data register.
  logic            wr_dir;         // Accepted direction write.
  logic            wr_data;        // Accepted data write.
  logic [15:0]     next_rdata;     // Read answer for the next cycle.
  logic            next_rvalid;    // Read strobe for the next cycle.
  logic [3:0]      next_sec_lvl;   // Secondary levels for the next cycle.

  // A single reset term keeps the three sources in step.
  assign any_rst = RST | PCIE_RST | GLOBAL_RESET_INPUT;

  ////////////////////////////////////////////////////////////////////////////
  // Secondary function map; pins without a function never leave the port.
  always_comb begin
    sec_enable = '0;
    sec_out    = '0;
    sec_oe_n   = '1;
    sec_enable[bgp_pkg::PIN_CLOCK_RUN]  = CLOCK_RUN_ENABLE;
    sec_out[bgp_pkg::PIN_CLOCK_RUN]     = CLOCK_RUN_OUT;
    sec_oe_n[bgp_pkg::PIN_CLOCK_RUN]    = CLOCK_RUN_OE_N;
    // The override is an input only, so the pin stays released.
    sec_enable[bgp_pkg::PIN_POWER_OVRD] = POWER_OVERRIDE_ENABLE;
    // The serial enable moves both serial lines together.
    sec_enable[bgp_pkg::PIN_SERIAL_CLK] =
      SERIAL_EEPROM_PRESENT_ENABLE;
    sec_out[bgp_pkg::PIN_SERIAL_CLK]    = SCL_OUT;
    sec_oe_n[bgp_pkg::PIN_SERIAL_CLK]   = SCL_OE_N;
    sec_enable[bgp_pkg::PIN_SERIAL_DAT] =
      SERIAL_EEPROM_PRESENT_ENABLE;
    sec_out[bgp_pkg::PIN_SERIAL_DAT]    = SDA_OUT;
    sec_oe_n[bgp_pkg::PIN_SERIAL_DAT]   = SDA_OE_N;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; only the low lane holds live bits.
  always_comb begin
    hit_dir  = 1'b0;
    hit_data = 1'b0;
    if (CFG_ADDR == bgp_pkg::OFS_PIN_DIRECTION_CONTROL) begin
      hit_dir = 1'b1;
    end else if (CFG_ADDR == bgp_pkg::OFS_PIN_LEVEL_DATA) begin
      hit_data = 1'b1;
    end
  end

  // The upper lane is reserved, so its strobe alone changes nothing.
  assign wr_dir  = CFG_WR & hit_dir
                 & CFG_BE[bgp_pkg::LANE_LIVE];
  assign wr_data = CFG_WR & hit_data & CFG_BE[bgp_pkg::LANE_LIVE];

  // Only output-mode pins that are not lent out take written data; the
  // current direction decides, so a same-cycle direction write is later.
  assign write_ok = direction & ~sec_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Direction and level registers.
  always_comb begin
    next_direction = direction;
    next_level     = level;
    if (wr_dir) begin
      next_direction =
        CFG_WDATA[bgp_pkg::FLD_HI:bgp_pkg::FLD_LO];
    end
    if (wr_data) begin
      next_level = (CFG_WDATA[bgp_pkg::FLD_HI:bgp_pkg::FLD_LO] & write_ok)
                 | (level & ~write_ok);
    end
  end

  always_ff @(posedge MCLK) begin
    if (any_rst) begin
      direction <= bgp_pkg::RST_DIRECTION;
      level     <= bgp_pkg::RST_LEVEL;
    end else begin
      direction <= next_direction;
      level     <= next_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: input and lent pins show the live level, driven ones show
  // the latch, which is what the pin carries one cycle later.
  assign read_level = (level & write_ok) | (GP_IN & ~write_ok);

  always_comb begin
    next_rdata  = 16'h0000;
    next_rvalid = CFG_RD;
    if (CFG_RD && hit_dir) begin
      next_rdata = {bgp_pkg::RSVD_READ, direction};
    end else if (CFG_RD && hit_data) begin
      // After reset every pin is an input, so this is the sampled level.
      next_rdata = {bgp_pkg::RSVD_READ, read_level};
    end
  end

  always_ff @(posedge MCLK) begin
    if (any_rst) begin
      CFG_RDATA  <= 16'h0000;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RDATA  <= next_rdata;
      CFG_RVALID <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Levels handed to the secondary functions, registered for clean timing.
  always_comb begin
    next_sec_lvl = {GP_IN[bgp_pkg::PIN_SERIAL_DAT],
                    GP_IN[bgp_pkg::PIN_SERIAL_CLK],
                    GP_IN[bgp_pkg::PIN_POWER_OVRD],
                    GP_IN[bgp_pkg::PIN_CLOCK_RUN]};
  end

  always_ff @(posedge MCLK) begin
    if (any_rst) begin
      CLOCK_RUN_FUNCTION   <= 1'b0;
      POWER_OVERRIDE_INPUT <= 1'b0;
      SCL_IN               <= 1'b0;
      SDA_IN               <= 1'b0;
    end else begin
      CLOCK_RUN_FUNCTION   <= next_sec_lvl[0];
      POWER_OVERRIDE_INPUT <= next_sec_lvl[1];
      SCL_IN               <= next_sec_lvl[2];
      SDA_IN               <= next_sec_lvl[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin drive cells.
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    bgp_pin_cell u_cell (
      .clk        (MCLK),
      .rst        (any_rst),
      .direction  (direction[i]),
      .level      (level[i]),
      .sec_enable (sec_enable[i]),
      .sec_out    (sec_out[i]),
      .sec_oe_n   (sec_oe_n[i]),
      .pin_out    (GP_OUT[i]),
      .pin_oe_n   (GP_OE_N[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_dir_reset: assert property (
    @(posedge MCLK) any_rst |=> (direction == '0) && (level == '0))
    else $error("direction or level not cleared by reset");

  chk_reset_release: assert property (
    @(posedge MCLK) any_rst |=> (GP_OE_N == '1))
    else $error("pin driven right after reset");

  chk_dir_write: assert property (
    @(posedge MCLK) disable iff (any_rst)
    wr_dir |=> direction == $past(CFG_WDATA[7:0]))
    else $error("direction write not stored");

  chk_rsvd_zero: assert property (
    @(posedge MCLK) disable iff (any_rst)
    CFG_RVALID |-> CFG_RDATA[15:8] == 8'h00)
    else $error("reserved byte not zero");

  chk_input_read: assert property (
    @(posedge MCLK) disable iff (any_rst)
    (CFG_RD && hit_data) |=>
      ((CFG_RDATA[7:0] ^ $past(GP_IN)) & ~$past(write_ok)) == '0)
    else $error("input pin level not returned");

  chk_write_discard: assert property (
    @(posedge MCLK) disable iff (any_rst)
    wr_data |=> ((level ^ $past(level)) & ~$past(write_ok)) == '0)
    else $error("write to input or lent pin took effect");

  chk_out_drive: assert property (
    @(posedge MCLK) disable iff (any_rst)
    wr_data ##1 (direction & ~sec_enable) == $past(write_ok) |=>
      ((GP_OUT ^ $past(CFG_WDATA[7:0], 2)) & $past(write_ok, 2)) == '0)
    else $error("written level not driven");

  chk_sec_isolate: assert property (
    @(posedge MCLK) disable iff (any_rst)
    1'b1 |=> ((GP_OE_N ^ $past(sec_oe_n)) & $past(sec_enable)) == '0)
    else $error("lent pin not under its function");

  chk_serial_pins: assert property (
    @(posedge MCLK) disable iff (any_rst)
    SERIAL_EEPROM_PRESENT_ENABLE |=>
      GP_OUT[4] == $past(SCL_OUT) && GP_OE_N[4] == $past(SCL_OE_N) &&
      GP_OUT[5] == $past(SDA_OUT) && GP_OE_N[5] == $past(SDA_OE_N))
    else $error("serial lines not on pins 4 and 5");

  chk_input_float: assert property (
    @(posedge MCLK) disable iff (any_rst)
    1'b1 |=> (~GP_OE_N & ~$past(direction) & ~$past(sec_enable)) == '0)
    else $error("input pin driven");

endmodule : bgp_gpio_port

`default_nettype wire

// *** logic/bgp_pin_cell.sv ***
// One pin of the general-purpose port: selects between the port's own
// direction and level and a secondary function, and registers the drive.
// Assumes the pin wire is resolved outside from the output enable.
`timescale 1ns/1ps
`default_nettype none

module bgp_pin_cell (
  // Clock and combined reset.
  input  wire logic clk,
  input  wire logic rst,
  // Port settings for this pin.
  input  wire logic direction,
  input  wire logic level,
  // Secondary function selection and drive.
  input  wire logic sec_enable,
  input  wire logic sec_out,
  input  wire logic sec_oe_n,
  // Registered pin drive; enable is low while driving.
  output logic      pin_out,
  output logic      pin_oe_n
);

  logic next_pin_out;  // Drive value for the next cycle.
  logic next_pin_oe_n; // Drive enable for the next cycle.

  ////////////////////////////////////////////////////////////////////////////
  // The secondary function takes the pin whole, so the port's direction
  // and level cannot disturb it while it is enabled.
  always_comb begin
    if (sec_enable) begin
      next_pin_out  = sec_out;
      next_pin_oe_n = sec_oe_n;
    end else if (direction) begin
      next_pin_out  = level;
      next_pin_oe_n = 1'b0;
    end else begin
      // Input mode: release the pin so the board sets its level.
      next_pin_out  = 1'b0;
      next_pin_oe_n = 1'b1;
    end
  end

  // Registering the drive avoids glitches on the pin while settings move.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

endmodule : bgp_pin_cell

`default_nettype wire

// *** logic/bgp_pkg.sv ***
// Constants for the bridge general-purpose pin port.
// Assumes a byte-addressed configuration access path with 16-bit data in two byte lanes.
`default_nettype none

package bgp_pkg;

  // Number of general-purpose pins on the port.
  localparam int unsigned PIN_COUNT = 8;

  // Configuration offsets of the two registers.
  localparam logic [7:0] OFS_PIN_DIRECTION_CONTROL = 8'hb4;
  localparam logic [7:0] OFS_PIN_LEVEL_DATA        = 8'hb6;

  // Reset values of the stored fields.
  localparam logic [7:0] RST_DIRECTION  = 8'h00;
  localparam logic [7:0] RST_LEVEL      = 8'h00;
  localparam logic [7:0] RST_READ       = 8'h00;

  // Reserved upper byte always reads as this value.
  localparam logic [7:0] RSVD_READ      = 8'h00;

  // Field positions: live bits sit in the low byte of each register.
  localparam int unsigned FLD_LO = 0;
  localparam int unsigned FLD_HI = 7;

  // Byte lane that carries the live bits.
  localparam int unsigned LANE_LIVE = 0;

  // Pins that share a secondary function.
  localparam int unsigned PIN_CLOCK_RUN  = 0;
  localparam int unsigned PIN_POWER_OVRD = 1;
  localparam int unsigned PIN_SERIAL_CLK = 4;
  localparam int unsigned PIN_SERIAL_DAT = 5;

  // Read latency in clock cycles from request to answer.
  localparam int unsigned READ_LATENCY = 1;

endpackage : bgp_pkg

`default_nettype wire

// *** sim/bgp_board.sv ***
// Board model for the eight general-purpose pins of the port.
// Assumes the port drives a pin while its enable is low; board pull-ups.
`timescale 1ns/1ps
`default_nettype none

module bgp_board (
  // Port side of each pin.
  input  wire logic [7:0] gp_out,
  input  wire logic [7:0] gp_oe_n,
  // Board drive for each pin.
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] ext_drive,
  // Resolved wire level fed back to the port.
  output logic      [7:0] gp_in
);
  //////////////////////////////////////////////////////////////////////
  // The port wins over the board so a clash never shows an unknown.
  // An undriven pin floats up to one through its pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!gp_oe_n[i]) begin
        gp_in[i] = gp_out[i];
      end else if (ext_drive[i]) begin
        gp_in[i] = ext_level[i];
      end else begin
        gp_in[i] = 1'h1;
      end
    end
  end
endmodule : bgp_board

`default_nettype wire

// *** sim/tb_bgp_gpio_port.sv ***
// Bench for the pin port: drives the configuration path, the resets
// and the secondary functions, with the board model on the pins.
`timescale 1ns/1ps
`default_nettype none

module tb_bgp_gpio_port;
  logic        mclk = 1'h0;      // 125 MHz clock.
  logic        rst = 1'h1;       // Power-on reset.
  logic        pcie_rst = 1'h0;  // Link reset.
  logic        global_reset_input = 1'h0;      // Global reset input.
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [1:0]  be = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        rvalid;
  logic        crun_en = 1'h0;
  logic        povr_en = 1'h0;
  logic        ser_en = 1'h0;
  logic        crun_out = 1'h0;
  logic        crun_oe_n = 1'h1;
  logic        scl_out = 1'h0;
  logic        scl_oe_n = 1'h1;
  logic        sda_out = 1'h0;
  logic        sda_oe_n = 1'h1;
  logic        crun_in;
  logic        povr_in;
  logic        scl_in;
  logic        sda_in;
  logic [7:0]  gp_in;
  logic [7:0]  gp_out;
  logic [7:0]  gp_oe_n;
  logic [7:0]  ext_level = 8'h96;  // Board pattern at power-up.
  logic [7:0]  ext_drive = 8'hff;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [15:0] d;

  always #4 mclk = ~mclk;

  bgp_gpio_port u_bgp_gpio_port (
    .MCLK(mclk), .RST(rst), .PCIE_RST(pcie_rst),
    .GLOBAL_RESET_INPUT(global_reset_input), .CFG_ADDR(addr), .CFG_WR(wr),
    .CFG_RD(rd), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
    .CFG_RVALID(rvalid), .CLOCK_RUN_ENABLE(crun_en),
    .POWER_OVERRIDE_ENABLE(povr_en),
    .SERIAL_EEPROM_PRESENT_ENABLE(ser_en), .CLOCK_RUN_OUT(crun_out),
    .CLOCK_RUN_OE_N(crun_oe_n), .SCL_OUT(scl_out), .SCL_OE_N(scl_oe_n),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .CLOCK_RUN_FUNCTION(crun_in), .POWER_OVERRIDE_INPUT(povr_in),
    .SCL_IN(scl_in), .SDA_IN(sda_in), .GP_IN(gp_in), .GP_OUT(gp_out),
    .GP_OE_N(gp_oe_n));

  bgp_board u_bgp_board (
    .gp_out(gp_out), .gp_oe_n(gp_oe_n), .ext_level(ext_level),
    .ext_drive(ext_drive), .gp_in(gp_in));

  //////////////////////////////////////////////////////////////////////
  // Shared tasks for comparing, bus cycles and waiting.
  task automatic check(input string what, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One write, held for one edge; a gap cycle follows before the next.
  task automatic cfg_wr(input logic [7:0] a, input logic [15:0] v,
                        input logic [1:0] b);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    be <= b;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask : cfg_wr

  // The answer stands one cycle only, so it is taken just after the edge.
  task automatic cfg_rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    check("read valid", {15'h0000, rvalid}, 16'h0001);
    v = rdata;
  endtask : cfg_rd

  // Pin outputs trail their causes by one registered stage.
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  //////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    cfg_rd(8'hb4, d);
    check("direction reset", d, 16'h0000);
    cfg_rd(8'hb6, d);
    check("data at power-up", d, 16'h0096);
    check("pins released", {8'h00, gp_oe_n}, 16'h00ff);
    cfg_rd(8'hb8, d);
    check("unmapped read", d, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_output();
    ext_drive <= 8'h00;
    cfg_wr(8'hb4, 16'hffff, 2'h3);
    cfg_wr(8'hb6, 16'hffa5, 2'h3);
    settle();
    check("drive enables", {8'h00, gp_oe_n}, 16'h0000);
    check("driven levels", {8'h00, gp_out}, 16'h00a5);
    cfg_wr(8'hb4, 16'h0000, 2'h2);  // Low lane off: must be ignored.
    cfg_rd(8'hb4, d);
    check("direction readback", d, 16'h00ff);
    cfg_rd(8'hb6, d);
    check("data readback", d, 16'h00a5);
    $display("test output done");
  endtask : t_output

  task automatic t_input();
    ext_drive <= 8'hf0;
    ext_level <= 8'h30;
    cfg_wr(8'hb4, 16'h000f, 2'h3);
    cfg_wr(8'hb6, 16'h0f5c, 2'h3);
    settle();
    check("half released", {8'h00, gp_oe_n}, 16'h00f0);
    cfg_rd(8'hb6, d);
    check("mixed read", d, 16'h003c);
    ext_drive <= 8'h00;
    cfg_wr(8'hb4, 16'h00ff, 2'h3);
    cfg_rd(8'hb6, d);
    check("dropped write", d, 16'h00ac);
    $display("test input done");
  endtask : t_input

  task automatic t_secondary();
    @(posedge mclk);
    {crun_en, povr_en, ser_en} <= 3'h7;
    // Clock run drives high, serial clock drives high, serial data low.
    {crun_out, crun_oe_n, scl_out, scl_oe_n, sda_out, sda_oe_n} <= 6'h28;
    ext_drive <= 8'h12;
    ext_level <= 8'h12;
    cfg_wr(8'hb6, 16'h0000, 2'h3);
    cfg_wr(8'hb4, 16'h0000, 2'h3);
    settle();
    check("shared enables", {8'h00, gp_oe_n}, 16'h00ce);
    check("shared drive",
          {13'h0, gp_out[5], gp_out[4], gp_out[0]}, 16'h0003);
    check("shared inputs",
          {12'h000, crun_in, povr_in, scl_in, sda_in}, 16'h000e);
    @(posedge mclk);
    ext_drive <= 8'h00;
    {crun_en, povr_en, ser_en} <= 3'h0;
    cfg_wr(8'hb4, 16'h00ff, 2'h3);
    settle();
    check("pins returned", {8'h00, gp_oe_n}, 16'h0000);
    check("kept levels", {8'h00, gp_out}, 16'h0020);
    $display("test secondary done");
  endtask : t_secondary

  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      cfg_wr(8'hb4, 16'h00ff, 2'h3);
      @(posedge mclk);
      rst <= (k == 0);
      pcie_rst <= (k == 1);
      global_reset_input <= (k == 2);
      @(posedge mclk);
      {rst, pcie_rst, global_reset_input} <= 3'h0;
      cfg_rd(8'hb4, d);
      check("direction cleared", d, 16'h0000);
      cfg_rd(8'hb6, d);
      check("floating pins read", d, 16'h00ff);
    end
    $display("test resets done");
  endtask : t_resets

  //////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the cycle ceiling.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // The whole run needs under a hundred cycles; 3000 means a hang.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_output();
    t_input();
    t_secondary();
    t_resets();
    stop_test();
  end
endmodule : tb_bgp_gpio_port

`default_nettype wire
